//--- adc_acquisition_sequencer.v
// four-channel simultaneous sample-and-hold conversion sequencer
//
// Notes on behaviour
// R01: acquisition lasts 20 clocks, whatever the number of channels.
// R02: every channel conversion takes 40 clocks, start to completion.
// R03: all four channels go into hold together, then the group's channels convert one by one.
// R04: group size comes from a control field and is never below two.
// R05: a group starts only from the conversion start pin, never from writes.
// R06: a one-cycle pwm cycle sync pulse marks every pwm period start.
// R07: results are 11-bit twos complement, mid-scale reads as zero.
// R08: the host holds conversion start high for at least one clock.
// R09: an early start waits until 20 reacquisition clocks have passed.
// R10: after reset only V and W convert; control bit 3 starts the group at U, sized by the count field.
// R11: with control bit 7 set, completion flags status bit 0; status read clears.
// R12: each channel keeps its result in its own register until overwritten.
`timescale 1ns/1ps
`include "adc_seq_defines.vh"
module adc_acquisition_sequencer (
    // clock and reset
    input  wire                     sys_clk_i,
    input  wire                     rst_i,
    // host pins
    input  wire                     conversion_start_i,
    output reg                      irq_o,
    output reg                      pwm_cycle_sync_o,
    // register port
    input  wire [`REG_ADDR_W-1:0]   addr_i,
    input  wire [`REG_DATA_W-1:0]   wdata_i,
    input  wire                     wr_i,
    input  wire                     rd_i,
    output reg  [`REG_DATA_W-1:0]   rdata_o,
    // converter core
    output reg                      sha_hold_o,
    output reg                      conv_start_o,
    output reg  [1:0]               conv_chan_o,
    input  wire [`RES_BITS-1:0]     conv_data_i
);
    localparam S_ACQ  = 2'd0;
    localparam S_WAIT = 2'd1;
    localparam S_CONV = 2'd2;

    localparam [5:0] ACQ_LAST  = `ACQ_CYCLES - 1;
    localparam [5:0] CONV_LAST = `CONV_CYCLES - 1;

    // channels in the group, clamped to two..four
    function [2:0] group_size;
        input [`REG_DATA_W-1:0] ctrl;
        reg   [2:0]             n;
        begin
            n = ctrl[`CTRL_CNT_MSB:`CTRL_CNT_LSB];
            if (!ctrl[`CTRL_MODE_BIT]) begin
                group_size = `MIN_GROUP; // R10
            end else if (n < `MIN_GROUP) begin
                group_size = `MIN_GROUP; // R04
            end else if (n > `MAX_GROUP) begin
                group_size = `MAX_GROUP;
            end else begin
                group_size = n; // R04
            end
        end
    endfunction

    // first channel: V in the reset mode, U otherwise
    function [1:0] first_chan;
        input [`REG_DATA_W-1:0] ctrl;
        begin
            first_chan = ctrl[`CTRL_MODE_BIT] ? 2'd0 : 2'd1; // R10
        end
    endfunction

    reg  [1:0]               state;
    reg  [5:0]               cnt;
    reg  [1:0]               last_ch;
    reg                      pend;
    reg                      store;
    reg  [`REG_DATA_W-1:0]   ctrl;
    reg  [`REG_DATA_W-1:0]   pwm_period;
    reg  [`FLAG_W-1:0]       status;
    reg  [`FLAG_W-1:0]       int_en;
    reg  [`FLAG_W-1:0]       next_status;
    reg  [`RES_BITS-1:0]     res_mem [0:`NUM_CH-1];
    reg  [`REG_DATA_W-1:0]   next_rdata;
    wire                     start_rise;
    wire                     pwm_pulse;
    wire                     group_done;
    wire [`RES_BITS-1:0]     twos_res;
    wire                     stat_rd;
    wire [2:0]               grp_size;
    wire [1:0]               grp_first;
    wire [1:0]               grp_last;
    wire                     conv_end;
    wire [`REG_DATA_W-1:0]   res_word;
    reg  [`REG_DATA_W-1:0]   status_word;

    sync_edge u_start_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (conversion_start_i),
        .level_o   (),
        .rise_o    (start_rise)
    );

    pwm_period_timer #(
        .W (`REG_DATA_W)
    ) u_pwm_timer (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .period_i  (pwm_period),
        .sync_o    (pwm_pulse)
    );

    // offset binary from the core: flip the msb for twos complement
    assign twos_res   = {~conv_data_i[`RES_BITS-1], conv_data_i[`RES_BITS-2:0]}; // R07
    assign stat_rd    = rd_i && (addr_i == `ADDR_STATUS);

    // group shape decoded once; a size of four wraps to zero in two bits, so last lands on aux
    assign grp_size   = group_size(ctrl);
    assign grp_first  = first_chan(ctrl);
    assign grp_last   = grp_first + grp_size[1:0] - 2'd1; // R04 R10
    assign conv_end   = (state == S_CONV) && (cnt == CONV_LAST);
    assign group_done = conv_end && (conv_chan_o == last_ch);

    // left justified, lsb reads zero
    assign res_word   = {res_mem[addr_i[1:0]], 1'b0}; // R12

    // live bits beside the sticky flags
    always @* begin
        status_word                 = {`REG_DATA_W{1'b0}};
        status_word[`FLAG_W-1:0]    = status;
        status_word[`STAT_BUSY_BIT] = (state == S_CONV);
        status_word[`STAT_PEND_BIT] = pend;
    end

    // a start is latched in any state and honoured once reacquired
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            pend <= 1'b0;
        end else if (start_rise) begin
            pend <= 1'b1; // R05
        end else if (state == S_WAIT) begin
            pend <= 1'b0;
        end
    end

    // sequencer; reset enters acquisition so the first group also waits
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            state        <= S_ACQ;
            cnt          <= 6'd0;
            sha_hold_o   <= 1'b0;
            conv_start_o <= 1'b0;
            conv_chan_o  <= 2'd0;
            last_ch      <= 2'd0;
            store        <= 1'b0;
        end else begin
            conv_start_o <= 1'b0;
            store        <= 1'b0;
            case (state)
                S_ACQ: begin
                    if (cnt == ACQ_LAST) begin
                        cnt   <= 6'd0;
                        state <= S_WAIT; // R01 R09
                    end else begin
                        cnt <= cnt + 6'd1;
                    end
                end
                S_WAIT: begin
                    if (pend || start_rise) begin
                        // mode and size are frozen for the whole group
                        sha_hold_o   <= 1'b1; // R03
                        conv_start_o <= 1'b1;
                        conv_chan_o  <= grp_first;
                        last_ch      <= grp_last;
                        cnt          <= 6'd0;
                        state        <= S_CONV; // R05
                    end
                end
                S_CONV: begin
                    if (cnt == CONV_LAST) begin
                        store <= 1'b1;
                        cnt   <= 6'd0;
                        if (conv_chan_o == last_ch) begin
                            sha_hold_o <= 1'b0;
                            state      <= S_ACQ; // R09
                        end else begin
                            conv_chan_o  <= conv_chan_o + 2'd1; // R03
                            conv_start_o <= 1'b1;
                        end
                    end else begin
                        cnt <= cnt + 6'd1; // R02
                    end
                end
                default: begin
                    state      <= S_ACQ;
                    cnt        <= 6'd0;
                    sha_hold_o <= 1'b0;
                end
            endcase
        end
    end

    // one result register per channel, written only by its own conversion
    genvar g;
    generate
        for (g = 0; g < `NUM_CH; g = g + 1) begin : g_res
            always @(posedge sys_clk_i) begin
                if (rst_i) begin
                    res_mem[g] <= {`RES_BITS{1'b0}};
                end else if (conv_end && conv_chan_o == g) begin
                    res_mem[g] <= twos_res; // R12 R07
                end
            end
        end
    endgenerate

    // writable registers; ctrl only shapes the group in the sequencer, so writes cannot start a group
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl <= `CTRL_RST;
        end else if (wr_i && addr_i == `ADDR_CTRL) begin
            ctrl <= wdata_i & `CTRL_WMASK; // R04 R10
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            int_en <= `INT_EN_RST;
        end else if (wr_i && addr_i == `ADDR_INT_EN) begin
            int_en <= wdata_i[`FLAG_W-1:0];
        end
    end

    // a larger period takes effect at the next reload; the timer restarts at once if the new period is at or below its count
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            pwm_period <= `PWM_PERIOD_RST;
        end else if (wr_i && addr_i == `ADDR_PWM_PERIOD) begin
            pwm_period <= wdata_i;
        end
    end

    // sticky flags: clear by status read or clear register, set wins
    always @* begin
        next_status = status;
        if (stat_rd) begin
            next_status = {`FLAG_W{1'b0}}; // R11
        end
        if (wr_i && addr_i == `ADDR_INT_CLR) begin
            next_status = next_status & ~wdata_i[`FLAG_W-1:0];
        end
        if (group_done && ctrl[`CTRL_IRQ_EN_BIT]) begin
            next_status[`STAT_DONE_BIT] = 1'b1; // R11
        end
        if (pwm_pulse) begin
            next_status[`STAT_SYNC_BIT] = 1'b1;
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            status           <= {`FLAG_W{1'b0}};
            irq_o            <= 1'b0;
            pwm_cycle_sync_o <= 1'b0;
        end else begin
            status           <= next_status;
            irq_o            <= |(next_status & int_en); // R11
            pwm_cycle_sync_o <= pwm_pulse; // R06
        end
    end

    // read data stand only in the cycle after the strobe
    always @* begin
        next_rdata = {`REG_DATA_W{1'b0}};
        if (!rd_i) begin
            next_rdata = {`REG_DATA_W{1'b0}};
        end else if (addr_i == `ADDR_CTRL) begin
            next_rdata = ctrl;
        end else if (addr_i == `ADDR_STATUS) begin
            next_rdata = status_word;
        end else if (addr_i == `ADDR_INT_EN) begin
            next_rdata[`FLAG_W-1:0] = int_en;
        end else if (addr_i == `ADDR_PWM_PERIOD) begin
            next_rdata = pwm_period;
        end else if (addr_i[3:2] == `ADDR_RES_BASE) begin
            next_rdata = res_word; // R12
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_o <= {`REG_DATA_W{1'b0}};
        end else begin
            rdata_o <= next_rdata;
        end
    end
endmodule

//--- adc_seq_assertions.sv
// port checker for the acquisition sequencer
`timescale 1ns/1ps
`include "adc_seq_defines.vh"
module adc_seq_checker (
    // watched ports
    input logic                   sys_clk_i,
    input logic                   rst_i,
    input logic                   conversion_start_i,
    input logic                   irq_o,
    input logic                   pwm_cycle_sync_o,
    input logic                   rd_i,
    input logic [`REG_DATA_W-1:0] rdata_o,
    input logic                   sha_hold_o,
    input logic                   conv_start_o,
    input logic [1:0]             conv_chan_o
);
    logic [7:0] hold_n;
    logic [7:0] idle_n;
    logic [7:0] gap_n;
    logic       req;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // idle and gap counters saturate so long idle spells never wrap
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            hold_n <= 8'h00;
            idle_n <= 8'h00;
            gap_n  <= 8'h00;
            req    <= 1'b0;
        end else begin
            hold_n <= sha_hold_o ? hold_n + 8'h01 : 8'h00;
            idle_n <= sha_hold_o ? 8'h00 : idle_n + {7'h00, idle_n != 8'hff};
            gap_n  <= conv_start_o ? 8'h01 : gap_n + {7'h00, gap_n != 8'hff};
            req    <= conversion_start_i | (req & !$rose(sha_hold_o));
        end
    end
    chk_acq_time: assert property ($rose(sha_hold_o) |-> idle_n >= 8'h14)
        else $error("hold came before reacquisition ended");
    chk_conv_space: assert property (conv_start_o && !$rose(sha_hold_o) |-> gap_n == 8'h28)
        else $error("conversion spacing wrong");
    chk_group_len: assert property ($fell(sha_hold_o) |-> hold_n inside {8'h50, 8'h78, 8'ha0})
        else $error("group length wrong");
    chk_hold_start: assert property ($rose(sha_hold_o) |-> conv_start_o)
        else $error("hold without first conversion");
    chk_start_held: assert property (conv_start_o |-> sha_hold_o)
        else $error("conversion outside hold");
    chk_pin_cause: assert property ($rose(sha_hold_o) |-> req)
        else $error("group without start pin");
    chk_sync_pulse: assert property (pwm_cycle_sync_o |=> !pwm_cycle_sync_o)
        else $error("sync pulse too long");
    chk_chan_steady: assert property (conv_start_o |=> $stable(conv_chan_o) [*8])
        else $error("channel moved in conversion");
    chk_rdata_idle: assert property (!rd_i |=> rdata_o == 12'h000)
        else $error("read data outside read slot");
    cov_group: cover property ($rose(sha_hold_o));
    cov_irq: cover property ($rose(irq_o));
    cov_sync: cover property (pwm_cycle_sync_o);
endmodule
bind adc_acquisition_sequencer adc_seq_checker i_chk (
    .sys_clk_i          (sys_clk_i),
    .rst_i              (rst_i),
    .conversion_start_i (conversion_start_i),
    .irq_o              (irq_o),
    .pwm_cycle_sync_o   (pwm_cycle_sync_o),
    .rd_i               (rd_i),
    .rdata_o            (rdata_o),
    .sha_hold_o         (sha_hold_o),
    .conv_start_o       (conv_start_o),
    .conv_chan_o        (conv_chan_o)
);

//--- adc_seq_defines.vh
// constants for the acquisition sequencer: offsets, fields, resets, timing
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH

// timing, in system clock cycles
`define ACQ_CYCLES       20
`define CONV_CYCLES      40

// geometry
`define NUM_CH           4
`define RES_BITS         11
`define REG_ADDR_W       4
`define REG_DATA_W       12
`define FLAG_W           2

// register offsets
`define ADDR_CTRL        4'h0
`define ADDR_STATUS      4'h1
`define ADDR_INT_CLR     4'h2
`define ADDR_INT_EN      4'h3
`define ADDR_PWM_PERIOD  4'h4
`define ADDR_RES_BASE    2'b10

// system_control_register fields
`define CTRL_MODE_BIT    3
`define CTRL_CNT_LSB     4
`define CTRL_CNT_MSB     6
`define CTRL_IRQ_EN_BIT  7
`define CTRL_WMASK       12'h0f8
`define CTRL_RST         12'h020

// system_status_register fields
`define STAT_DONE_BIT    0
`define STAT_SYNC_BIT    1
`define STAT_BUSY_BIT    2
`define STAT_PEND_BIT    3

// reset values and group size limits
`define INT_EN_RST       2'h0
`define PWM_PERIOD_RST   12'h3e8
`define MIN_GROUP        3'h2
`define MAX_GROUP        3'h4

`endif

//--- conv_core_model.sv
// converter core stand-in giving each channel a fixed code
`timescale 1ns/1ps
module conv_core_model (
    // clock and sequencer side
    input  logic        sys_clk_i,
    input  logic        hold_i,
    input  logic [1:0]  chan_i,
    input  logic        code_sel_i,
    output logic [10:0] data_o
);
    logic tog = 1'b0;
    always @(posedge sys_clk_i) tog <= !tog;
    // offset binary, channel 0 at mid-scale; nothing stable when not held
    always @* begin
        data_o = ({chan_i, 9'h000} ^ 11'h400) ^ {11{code_sel_i}};
        if (!hold_i) data_o = {11{tog}};
    end
endmodule

//--- pwm_period_timer.v
// pwm period counter giving a one-cycle pulse at each period start
`timescale 1ns/1ps
module pwm_period_timer #(
    parameter W = 12
) (
    // clock and reset
    input  wire         sys_clk_i,
    input  wire         rst_i,
    // period in system clocks, zero stops the timer
    input  wire [W-1:0] period_i,
    // one-cycle pulse
    output reg          sync_o
);
    reg [W-1:0] count;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            count  <= {W{1'b0}};
            sync_o <= 1'b0;
        end else if (period_i == {W{1'b0}}) begin
            count  <= {W{1'b0}};
            sync_o <= 1'b0;
        end else if (count == {W{1'b0}} || count >= period_i) begin
            // shrinking the period restarts cleanly instead of wrapping
            count  <= period_i - {{(W-1){1'b0}}, 1'b1};
            sync_o <= 1'b1; // R06
        end else begin
            count  <= count - {{(W-1){1'b0}}, 1'b1};
            sync_o <= 1'b0;
        end
    end
endmodule

//--- sync_edge.v
// two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ps
module sync_edge (
    // clock and reset
    input  wire sys_clk_i,
    input  wire rst_i,
    // pin side
    input  wire async_i,
    // synchronised side
    output reg  level_o,
    output reg  rise_o
);
    reg meta;
    reg prev;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta    <= 1'b0;
            level_o <= 1'b0;
            prev    <= 1'b0;
            rise_o  <= 1'b0;
        end else begin
            meta    <= async_i;
            level_o <= meta;
            prev    <= level_o;
            rise_o  <= level_o & ~prev;
        end
    end
endmodule

//--- tb_adc_acquisition_sequencer.sv
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
module tb_adc_acquisition_sequencer;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        start = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        sel = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [11:0] wdata = 12'h000;
    logic [11:0] rdata, d;
    logic        irq, sync, hold, cst;
    logic [1:0]  chan;
    logic [10:0] cdata;
    logic [2:0]  sz [4] = '{3'h0, 3'h3, 3'h7, 3'h2};
    int          n_errors = 0;
    int          checks_done = 0;
    int          c;
    always #2 sys_clk_i = !sys_clk_i;
    adc_acquisition_sequencer i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .conversion_start_i(start), .irq_o(irq), .pwm_cycle_sync_o(sync), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sha_hold_o(hold),
        .conv_start_o(cst), .conv_chan_o(chan), .conv_data_i(cdata));
    conv_core_model i_core (.sys_clk_i(sys_clk_i), .hold_i(hold), .chan_i(chan),
        .code_sel_i(sel), .data_o(cdata));
    task close_out;
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [11:0] v);
        @(posedge sys_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a);
        @(posedge sys_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task wait_hold(input logic v);
        c = 0;
        while (hold !== v) begin
            @(posedge sys_clk_i);
            #1 c++;
            if (c > 400) begin
                n_errors++;
                close_out;
            end
        end
    endtask
    // early groups start right after the previous one to force the wait
    task group(input logic [11:0] ctl, input logic [1:0] ch0, input int n, input logic s, input logic early);
        wr_reg(4'h0, ctl);
        @(posedge sys_clk_i);
        start <= 1'b1;
        sel <= s;
        repeat (2) @(posedge sys_clk_i);
        start <= 1'b0;
        wait_hold(1'b1);
        if (early) chk("reacq wait", 12'h001, {11'h0, c >= 15 && c <= 22});
        chk("first chan", {10'h0, ch0}, {10'h0, chan});
        chk("first start", 12'h001, {11'h0, cst});
        wait_hold(1'b0);
        chk("group cycles", 12'(40 * n), 12'(c));
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd_reg(4'h0);
        chk("ctrl reset", 12'h020, d);
        rd_reg(4'h3);
        chk("int enable reset", 12'h000, d);
        rd_reg(4'h7);
        chk("unmapped read", 12'h000, d);
        wr_reg(4'h3, 12'h001);
        repeat (25) @(posedge sys_clk_i);
        #1 chk("no start by write", 12'h000, {11'h0, hold});
        group(12'h0c8, 2'h0, 4, 1'b0, 1'b0);
        group(12'h080, 2'h1, 2, 1'b1, 1'b1);
        chk("irq at done", 12'h001, {11'h0, irq});
        for (int i = 0; i < 4; i++) begin
            rd_reg(4'h8 + 4'(i));
            chk("result", {{2'(i), 9'h000} ^ {11{i == 1 || i == 2}}, 1'b0}, d);
        end
        rd_reg(4'h1);
        chk("done flag", 12'h001, d & 12'h001);
        repeat (2) @(posedge sys_clk_i);
        #1 chk("irq after status read", 12'h000, {11'h0, irq});
        wr_reg(4'h3, 12'h000);
        for (int k = 0; k < 4; k++)
            group({5'h01, sz[k], 4'h8}, 2'h0, sz[k] < 2 ? 2 : sz[k] > 4 ? 4 : sz[k], 1'b0, 1'b0);
        #1 chk("irq masked", 12'h000, {11'h0, irq});
        wr_reg(4'h3, 12'h001);
        repeat (2) @(posedge sys_clk_i);
        #1 chk("irq unmasked", 12'h001, {11'h0, irq});
        wr_reg(4'h2, 12'h001);
        repeat (2) @(posedge sys_clk_i);
        #1 chk("irq cleared", 12'h000, {11'h0, irq});
        wr_reg(4'h4, 12'h00a);
        for (int k = 0; k < 3; k++) begin
            c = 0;
            do begin
                @(posedge sys_clk_i);
                #1 c++;
            end while (sync !== 1'b1 && c < 50);
            if (c >= 50) n_errors++;
            if (c >= 50) close_out;
            if (k > 0) chk("sync period", 12'h00a, 12'(c));
        end
        close_out;
    end
endmodule
